// ==== hw/nvm_ctrl_device.sv ====
// nvm device end: banked ram/eeprom window, control register, row write
// assumes: the core master keeps strobes one cycle and never overlapping
//
// Operation
// - selected 64-byte bank appears at 00h-3Fh
// - armed accesses are writes; latches held
// - software touches only the latched row
// - software does not read eeprom while armed
// - arming clears all eight row latches
// - go programs only bytes written since arm
// - arm self-clears after programming; rearm each time
// - go ignored unless unlock and arm set
// - software keeps bank select fixed while armed
// - control register resets to zero
// - standby bit 6 disables eeprom access
// - go bit 3 programs row, self-clears
// - row is A6-A3 of the index, byte is A2-A0
// - clearing arm before go abandons row
// - busy bit 1 set while programming
// - accesses during busy aborted, programming continues
// - software waits for busy clear first
// - no write cycle while unlock low
// - stop instruction disables the eeprom
// - bank select e8h, control eah, decoded
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "nvm_defines.svh"
module nvm_ctrl_device (
  input  wire logic          clock_i,
  input  wire logic          rstn_i,
  nvm_bus_if.nvm             bus,
  output nvm_pkg::prog_state_e prog_state_o,
  output logic               busy_o,
  output logic               standby_o
);
  import nvm_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  localparam byte_t       CTRL_RST = `NVM_CTRL_RESET; // reset image
  prog_state_e            state_q;
  prog_state_e            state_d;
  logic                   unlock_q;
  logic                   arm_q;
  logic                   go_q;
  logic                   standby_q;
  logic [1:0]             bank_q;
  byte_t                  ram_q [64];
  byte_t                  ee_q [128];
  byte_t                  latch_q [8];
  logic [7:0]             mask_q;
  logic [3:0]             row_q;
  logic                   row_valid_q;
  logic                   single_q;
  ee_index_t              single_idx_q;
  byte_t                  single_data_q;
  logic [`NVM_CNT_W-1:0]  cnt_q;
  byte_t                  rdata_q;
  byte_t                  rd_mux;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  // window and register decode
  wire       busy      = (state_q == PROG_RUN);
  wire       ee_off    = standby_q | bus.stop;
  wire       in_win    = (bus.addr <= `NVM_WINDOW_LAST);
  wire       sel_ram   = in_win & (bank_q == `NVM_BANK_RAM);
  wire       sel_ee    = in_win & ((bank_q == `NVM_BANK_EE0)
                                 | (bank_q == `NVM_BANK_EE1));
  wire       ee_ok     = sel_ee & ~busy & ~ee_off;
  wire       ctrl_wr   = bus.wr & (bus.addr == `NVM_ADDR_CTRL);
  wire       bank_wr   = bus.wr & (bus.addr == `NVM_ADDR_BANK_SEL);
  wire [6:0] acc_idx   = ee_index(bank_q, bus.addr);
  wire [3:0] acc_row   = acc_idx[6:3];
  wire [2:0] acc_byte  = acc_idx[2:0];

  // request decode
  wire row_ld    = bus.wr & ee_ok & arm_q;
  wire single_go = bus.wr & ee_ok & ~arm_q & unlock_q;
  wire go_ok     = ctrl_wr & bus.wdata[`NVM_BIT_GO]
                 & unlock_q & arm_q & ~busy;
  wire arm_rise  = ctrl_wr & bus.wdata[`NVM_BIT_ARM] & ~arm_q & ~busy;
  wire arm_drop  = ctrl_wr & ~bus.wdata[`NVM_BIT_ARM] & arm_q
                 & ~busy & ~go_ok;
  wire prog_done = busy & (cnt_q == '0);
  wire row_done  = prog_done & go_q;

  // ----------------------------------------------------------------------
  // control and bank select registers
  // ----------------------------------------------------------------------
  // control bits, bank select, arm and go handshake
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      unlock_q  <= CTRL_RST[`NVM_BIT_UNLOCK];
      standby_q <= CTRL_RST[`NVM_BIT_STANDBY];
      arm_q     <= CTRL_RST[`NVM_BIT_ARM];
      go_q      <= CTRL_RST[`NVM_BIT_GO];
      bank_q    <= `NVM_BANK_RESET;
    end else begin
      if (ctrl_wr) begin
        unlock_q  <= bus.wdata[`NVM_BIT_UNLOCK];
        standby_q <= bus.wdata[`NVM_BIT_STANDBY];
      end
      if (bank_wr) begin
        bank_q <= bus.wdata[1:0];
      end
      if (row_done) begin
        arm_q <= 1'b0;
        go_q  <= 1'b0;
      end else if (go_ok) begin
        go_q <= 1'b1;
      end else if (arm_rise) begin
        arm_q <= 1'b1;
      end else if (arm_drop) begin
        arm_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // row latches
  // ----------------------------------------------------------------------
  // volatile row data, written-byte mask and latched row address
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      mask_q      <= 8'h00;
      row_q       <= 4'h0;
      row_valid_q <= 1'b0;
      for (int i = 0; i < `NVM_ROW_BYTES; i++) begin
        latch_q[i] <= 8'h00;
      end
    end else if (arm_rise | arm_drop | row_done) begin
      mask_q      <= 8'h00;
      row_valid_q <= 1'b0;
      for (int i = 0; i < `NVM_ROW_BYTES; i++) begin
        latch_q[i] <= 8'h00;
      end
    end else if (row_ld) begin
      if (!row_valid_q) begin
        row_q       <= acc_row;
        row_valid_q <= 1'b1;
      end
      latch_q[acc_byte] <= bus.wdata;
      mask_q[acc_byte]  <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // programming sequencer
  // ----------------------------------------------------------------------
  // next state of the programming machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      PROG_IDLE: begin
        if (single_go | go_ok) begin
          state_d = PROG_RUN;
        end
      end
      PROG_RUN: begin
        if (cnt_q == '0) begin
          state_d = PROG_IDLE;
        end
      end
      default: begin
        state_d = PROG_IDLE;
      end
    endcase
  end

  // state, interval counter and single-byte job
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      state_q       <= PROG_IDLE;
      cnt_q         <= '0;
      single_q      <= 1'b0;
      single_idx_q  <= 7'h00;
      single_data_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (single_go | go_ok) begin
        cnt_q <= `NVM_CNT_W'(`NVM_PROG_CYCLES - 1);
      end else if (busy && cnt_q != '0) begin
        cnt_q <= cnt_q - `NVM_CNT_W'(1);
      end
      if (single_go) begin
        single_q      <= 1'b1;
        single_idx_q  <= acc_idx;
        single_data_q <= bus.wdata;
      end else if (go_ok) begin
        single_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  // ram bank writes and eeprom cell updates at end of interval
  always_ff @(posedge clock_i) begin
    if (bus.wr && sel_ram) begin
      ram_q[bus.addr[5:0]] <= bus.wdata;
    end
    if (prog_done) begin
      if (single_q) begin
        ee_q[single_idx_q] <= single_data_q;
      end else begin
        for (int i = 0; i < `NVM_ROW_BYTES; i++) begin
          if (mask_q[i]) begin
            ee_q[{row_q, 3'(i)}] <= latch_q[i];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  // read selection; write-only bits and unmapped space read zero
  always_comb begin
    rd_mux = 8'h00;
    if (bus.addr == `NVM_ADDR_CTRL) begin
      rd_mux[`NVM_BIT_BUSY] = busy;
    end else if (sel_ram) begin
      rd_mux = ram_q[bus.addr[5:0]];
    end else if (ee_ok && !arm_q) begin
      rd_mux = ee_q[acc_idx];
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= bus.rd ? rd_mux : 8'h00;
    end
  end

  // outputs
  assign bus.rdata    = rdata_q;
  assign prog_state_o = state_q;
  assign busy_o       = busy;
  assign standby_o    = standby_q;

endmodule : nvm_ctrl_device

// ==== hw/nvm_defines.svh ====
// offsets, bit positions, reset values and timing counts of the nvm block
// assumes: a 250 MHz core clock shared by both ends
`ifndef NVM_DEFINES_SVH
`define NVM_DEFINES_SVH

// ----------------------------------------------------------------------
// data space map
// ----------------------------------------------------------------------
`define NVM_WINDOW_LAST   8'h3f
`define NVM_ADDR_BANK_SEL 8'he8
`define NVM_ADDR_CTRL     8'hea

// ----------------------------------------------------------------------
// control register fields and reset values
// ----------------------------------------------------------------------
`define NVM_CTRL_RESET    8'h00
`define NVM_BIT_UNLOCK    0
`define NVM_BIT_BUSY      1
`define NVM_BIT_ARM       2
`define NVM_BIT_GO        3
`define NVM_BIT_STANDBY   6
`define NVM_ROW_BYTES     8

// ----------------------------------------------------------------------
// bank select codes
// ----------------------------------------------------------------------
`define NVM_BANK_RAM      2'h0
`define NVM_BANK_EE0      2'h1
`define NVM_BANK_EE1      2'h2
`define NVM_BANK_RESET    2'h0

// ----------------------------------------------------------------------
// programming interval
// ----------------------------------------------------------------------
`define NVM_CLK_PERIOD_NS 4
`define NVM_PROG_TIME_NS  5000
`define NVM_PROG_CYCLES   ((`NVM_PROG_TIME_NS + `NVM_CLK_PERIOD_NS - 1) \
                           / `NVM_CLK_PERIOD_NS)
`define NVM_CNT_W         11

`endif

// ==== hw/nvm_pkg.sv ====
// types and shared decode for the nvm device and its core-side master
// assumes: nvm_defines.svh on the include path
package nvm_pkg;
  `include "nvm_defines.svh"

  typedef logic [7:0] byte_t;
  typedef logic [6:0] ee_index_t;

  typedef enum logic [1:0] {
    PROG_IDLE = 2'b01,
    PROG_RUN  = 2'b10
  } prog_state_e;

  typedef enum logic [4:0] {
    H_IDLE   = 5'b00001,
    H_POLL   = 5'b00010,
    H_CHECK  = 5'b00100,
    H_ACCESS = 5'b01000,
    H_RDATA  = 5'b10000
  } host_state_e;

  // byte index into the two eeprom pages; row is the upper four bits
  function automatic ee_index_t ee_index(input logic [1:0] bank,
                                         input byte_t      addr);
    ee_index = {bank == `NVM_BANK_EE1, addr[5:0]};
  endfunction : ee_index

endpackage : nvm_pkg

// ==== hw/nvm_bus_if.sv ====
// internal data bus between processor core and nvm device
// assumes: both ends on clock_i; testbench joins the two modports
`timescale 1ns/1ps
interface nvm_bus_if (
  input wire logic clock_i
);
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       stop;

  modport core (output addr, output wdata, output wr, output rd,
                output stop, input rdata);
  modport nvm  (input addr, input wdata, input wr, input rd,
                input stop, output rdata);
endinterface : nvm_bus_if

// ==== hw/nvm_core_master.sv ====
// core end: turns user requests into bus cycles, polls busy before eeprom accesses
// assumes: user logic on clock_i, one request at a time
`timescale 1ns/1ps
`include "nvm_defines.svh"
module nvm_core_master (
  input  wire logic          clock_i,
  input  wire logic          rstn_i,
  input  wire logic          stop_i,
  input  wire logic          req_valid_i,
  input  wire logic          req_write_i,
  input  nvm_pkg::byte_t     req_addr_i,
  input  nvm_pkg::byte_t     req_wdata_i,
  output logic               req_ready_o,
  output logic               resp_valid_o,
  output logic               resp_refused_o,
  output nvm_pkg::byte_t     resp_rdata_o,
  nvm_bus_if.core            bus
);
  import nvm_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  host_state_e state_q;
  host_state_e state_d;
  byte_t       addr_q;
  byte_t       wdata_q;
  byte_t       rdata_q;
  logic        write_q;
  logic        resp_q;
  logic        refused_q;
  logic        stop_q;
  logic [1:0]  bank_sh_q;
  logic        arm_sh_q;
  logic        unlock_sh_q;
  logic        row_vld_q;
  logic [3:0]  row_sh_q;

  // ----------------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------------
  // request classification against shadowed device state
  wire       accept   = req_valid_i & (state_q == H_IDLE);
  wire       req_win  = (req_addr_i <= `NVM_WINDOW_LAST);
  wire       req_ee   = req_win & ((bank_sh_q == `NVM_BANK_EE0)
                                 | (bank_sh_q == `NVM_BANK_EE1));
  wire [6:0] req_idx  = ee_index(bank_sh_q, req_addr_i);
  wire       ctrl_w   = req_write_i & (req_addr_i == `NVM_ADDR_CTRL);
  wire       go_w     = ctrl_w & req_wdata_i[`NVM_BIT_GO]
                      & unlock_sh_q & arm_sh_q;
  wire       arm_next = go_w ? 1'b0 : req_wdata_i[`NVM_BIT_ARM];
  wire       refuse   =
      (req_write_i & (req_addr_i == `NVM_ADDR_BANK_SEL) & arm_sh_q)
    | (req_ee & arm_sh_q & ~req_write_i)
    | (req_ee & arm_sh_q & row_vld_q & (req_idx[6:3] != row_sh_q))
    | (req_ee & req_write_i & ~unlock_sh_q);

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  // next state: eeprom accesses poll busy first
  always_comb begin
    state_d = state_q;
    case (state_q)
      H_IDLE: begin
        if (accept && !refuse) begin
          state_d = req_ee ? H_POLL : H_ACCESS;
        end
      end
      H_POLL: begin
        state_d = H_CHECK;
      end
      H_CHECK: begin
        state_d = bus.rdata[`NVM_BIT_BUSY] ? H_POLL : H_ACCESS;
      end
      H_ACCESS: begin
        state_d = write_q ? H_IDLE : H_RDATA;
      end
      H_RDATA: begin
        state_d = H_IDLE;
      end
      default: begin
        state_d = H_IDLE;
      end
    endcase
  end

  // request capture and response
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      state_q   <= H_IDLE;
      addr_q    <= 8'h00;
      wdata_q   <= 8'h00;
      write_q   <= 1'b0;
      rdata_q   <= 8'h00;
      resp_q    <= 1'b0;
      refused_q <= 1'b0;
      stop_q    <= 1'b0;
    end else begin
      state_q   <= state_d;
      stop_q    <= stop_i;
      resp_q    <= (accept & refuse) | (state_q == H_RDATA)
                 | ((state_q == H_ACCESS) & write_q);
      refused_q <= accept & refuse;
      if (accept) begin
        addr_q  <= req_addr_i;
        wdata_q <= req_wdata_i;
        write_q <= req_write_i;
      end
      if (state_q == H_RDATA) begin
        rdata_q <= bus.rdata;
      end
    end
  end

  // shadow of bank, unlock, arm and latched row
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      bank_sh_q   <= `NVM_BANK_RESET;
      arm_sh_q    <= 1'b0;
      unlock_sh_q <= 1'b0;
      row_vld_q   <= 1'b0;
      row_sh_q    <= 4'h0;
    end else if (accept && !refuse) begin
      if (req_write_i && req_addr_i == `NVM_ADDR_BANK_SEL) begin
        bank_sh_q <= req_wdata_i[1:0];
      end
      if (ctrl_w) begin
        unlock_sh_q <= req_wdata_i[`NVM_BIT_UNLOCK];
        arm_sh_q    <= arm_next;
        row_vld_q   <= row_vld_q & arm_sh_q & arm_next;
      end else if (req_ee && req_write_i && arm_sh_q && !row_vld_q) begin
        row_sh_q  <= req_idx[6:3];
        row_vld_q <= 1'b1;
      end
    end
  end

  // bus drive
  assign bus.addr       = (state_q == H_POLL) ? `NVM_ADDR_CTRL : addr_q;
  assign bus.wdata      = wdata_q;
  assign bus.wr         = (state_q == H_ACCESS) & write_q;
  assign bus.rd         = (state_q == H_POLL)
                        | ((state_q == H_ACCESS) & ~write_q);
  assign bus.stop       = stop_q;
  assign req_ready_o    = (state_q == H_IDLE);
  assign resp_valid_o   = resp_q;
  assign resp_refused_o = refused_q;
  assign resp_rdata_o   = rdata_q;

endmodule : nvm_core_master

// ==== verification/nvm_bus_assertions.sv ====
// checker for the bus between core master and nvm device
// assumes: instantiated beside the bus interface, one clock domain
`timescale 1ns/1ps
`include "nvm_defines.svh"
module nvm_bus_assertions (
  input wire logic                 clock_i,
  input wire logic                 rstn_i,
  input wire logic [7:0]           addr,
  input wire logic [7:0]           wdata,
  input wire logic                 wr,
  input wire logic                 rd,
  input wire logic [7:0]           rdata,
  input wire logic                 stop,
  input wire nvm_pkg::prog_state_e prog_state_o,
  input wire logic                 busy_o,
  input wire logic                 standby_o
);
  import nvm_pkg::*;
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  localparam int PROG_CYC = `NVM_PROG_CYCLES;
  logic [11:0] busy_cnt_q;
  logic [1:0]  bank_q;
  // non-ram bank selected and window address on the bus
  wire         ee_win = addr <= `NVM_WINDOW_LAST && bank_q != `NVM_BANK_RAM;
  wire         ctl_sel = addr == `NVM_ADDR_CTRL;

  // busy length counter and shadow of the bank select
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      busy_cnt_q <= 12'h000;
      bank_q     <= `NVM_BANK_RESET;
    end else begin
      busy_cnt_q <= busy_o ? busy_cnt_q + 12'h001 : 12'h000;
      if (wr && addr == `NVM_ADDR_BANK_SEL) begin
        bank_q <= wdata[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  AST_BUSY_STATE: assert property (
    busy_o == (prog_state_o == PROG_RUN))
    else $error("busy flag disagrees with state");
  AST_RDATA_IDLE: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero outside read answer");
  AST_CTRL_READ: assert property (rd && ctl_sel |=>
    rdata == {6'h00, $past(busy_o), 1'b0})
    else $error("control read does not show only busy");
  AST_BANK_READ: assert property (
    rd && addr == `NVM_ADDR_BANK_SEL |=> rdata == 8'h00)
    else $error("bank select readable");
  AST_BUSY_LEN: assert property (
    $fell(busy_o) |-> busy_cnt_q == PROG_CYC)
    else $error("programming interval wrong length");
  AST_BUSY_BOUND: assert property (
    busy_o |-> busy_cnt_q < PROG_CYC)
    else $error("programming interval too long");
  AST_PROG_CAUSE: assert property (
    $rose(busy_o) |-> $past(wr))
    else $error("programming started without a write");
  AST_EE_OFF: assert property (rd && ee_win &&
    (busy_o || stop || standby_o) |=> rdata == 8'h00)
    else $error("eeprom answered while disabled");
  AST_STANDBY_WR: assert property (wr && ctl_sel |=>
    standby_o == $past(wdata[`NVM_BIT_STANDBY]))
    else $error("standby bit not taken from control write");
  AST_POLL_FIRST: assert property ((rd || wr) && ee_win |->
    $past(rd, 2) && $past(addr, 2) == `NVM_ADDR_CTRL && !$past(rdata[1]))
    else $error("eeprom access without busy poll");

  // main scenarios seen
  COV_PROG_END: cover property ($fell(busy_o));
  COV_STOP_RD: cover property (rd && stop && ee_win);
  COV_STBY_RD: cover property (rd && standby_o && ee_win);
  COV_GO_WR: cover property (wr && ctl_sel && wdata[`NVM_BIT_GO]);
endmodule : nvm_bus_assertions

// ==== verification/eeprom_row_write_control_bench.sv ====
// self-checking bench joining the core master and the nvm device
// assumes: nvm_pkg, nvm_bus_if and both design ends compiled first
`timescale 1ns/1ps
`include "nvm_defines.svh"
module eeprom_row_write_control_bench;
  import nvm_pkg::*;
  typedef struct packed {
    logic  refd;
    logic  rdchk;
    byte_t data;
  } exp_s;
  logic        clock_i;
  logic        rstn_i;
  logic        stop_i;
  logic        req_valid_i;
  logic        req_write_i;
  byte_t       req_addr_i;
  byte_t       req_wdata_i;
  logic        req_ready_o;
  logic        resp_valid_o;
  logic        resp_refused_o;
  byte_t       resp_rdata_o;
  prog_state_e prog_state_o;
  logic        busy_o;
  logic        standby_o;
  exp_s        exp_q[$];
  exp_s        e;
  int          err_total;
  int          n_tests;
  int          seed;
  byte_t       row[8];
  byte_t       v;
  byte_t       u;
  localparam byte_t CTL = `NVM_ADDR_CTRL;
  localparam byte_t BNK = `NVM_ADDR_BANK_SEL;

  // ----------------------------------------------------------------
  // both ends across one bus
  // ----------------------------------------------------------------
  nvm_bus_if nvm_bus_if_inst (.clock_i(clock_i));
  nvm_ctrl_device nvm_ctrl_device_inst (
    .clock_i(clock_i), .rstn_i(rstn_i), .bus(nvm_bus_if_inst),
    .prog_state_o(prog_state_o), .busy_o(busy_o), .standby_o(standby_o));
  nvm_core_master nvm_core_master_inst (
    .clock_i(clock_i), .rstn_i(rstn_i), .stop_i(stop_i),
    .req_valid_i(req_valid_i), .req_write_i(req_write_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_ready_o(req_ready_o), .resp_valid_o(resp_valid_o),
    .resp_refused_o(resp_refused_o), .resp_rdata_o(resp_rdata_o),
    .bus(nvm_bus_if_inst));
  nvm_bus_assertions nvm_bus_assertions_inst (
    .clock_i(clock_i), .rstn_i(rstn_i), .addr(nvm_bus_if_inst.addr),
    .wdata(nvm_bus_if_inst.wdata), .wr(nvm_bus_if_inst.wr),
    .rd(nvm_bus_if_inst.rd), .rdata(nvm_bus_if_inst.rdata),
    .stop(nvm_bus_if_inst.stop), .prog_state_o(prog_state_o),
    .busy_o(busy_o), .standby_o(standby_o));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic chk1(input string what, input logic exp, input logic got);
    check(what, {7'h00, exp}, {7'h00, got});
  endtask : chk1

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // one request, noted in the queue, held until taken, then awaited
  task automatic req(input logic w, input byte_t a, input byte_t d,
                     input logic refd, input byte_t x);
    int n;
    exp_q.push_back('{refd, !w && !refd, x});
    @(posedge clock_i);
    req_valid_i <= 1'b1;
    req_write_i <= w;
    req_addr_i  <= a;
    req_wdata_i <= d;
    n = 0;
    @(negedge clock_i);
    while (req_ready_o !== 1'b1 && n < 20) begin
      @(negedge clock_i);
      n++;
    end
    @(posedge clock_i);
    req_valid_i <= 1'b0;
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (resp_valid_o !== 1'b1 && n < 4000);
    chk1("resp_valid_o", 1'b1, resp_valid_o);
  endtask : req

  task automatic wr8(input byte_t a, input byte_t d);
    req(1'b1, a, d, 1'b0, 8'h00);
  endtask : wr8

  task automatic rd8(input byte_t a, input byte_t x);
    req(1'b0, a, 8'h00, 1'b0, x);
  endtask : rd8

  // clock and watchdog
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  initial begin
    #200000;
    err_total++;
    wrap_up();
  end

  // response watcher: oldest note against each response
  always @(negedge clock_i) begin
    if (resp_valid_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("resp_queue", 8'h00, 8'h01);
      end else begin
        e = exp_q.pop_front();
        chk1("resp_refused_o", e.refd, resp_refused_o);
        if (e.rdchk) begin
          check("resp_rdata_o", e.data, resp_rdata_o);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 99392;
    err_total = 0;
    n_tests = 0;
    rstn_i = 1'b0;
    stop_i = 1'b0;
    req_valid_i = 1'b0;
    req_write_i = 1'b0;
    req_addr_i = 8'h00;
    req_wdata_i = 8'h00;
    repeat (5) @(posedge clock_i);
    rstn_i <= 1'b1;
    @(negedge clock_i);
    chk1("busy_o", 1'b0, busy_o);
    chk1("standby_o", 1'b0, standby_o);
    chk1("req_ready_o", 1'b1, req_ready_o);
    check("prog_state_o", {6'h00, PROG_IDLE}, {6'h00, prog_state_o});
    rd8(CTL, 8'h00);
    rd8(BNK, 8'h00);
    $display("done: reset");
    for (int i = 0; i < 2; i++) begin
      v = 8'($random(seed));
      wr8(i ? 8'h3f : 8'h00, v);
      rd8(i ? 8'h3f : 8'h00, v);
    end
    $display("done: ram window");
    wr8(BNK, 8'(`NVM_BANK_EE0));
    req(1'b1, 8'h05, 8'h00, 1'b1, 8'h00);
    wr8(CTL, 8'h01);
    v = 8'($random(seed));
    wr8(8'h05, v);
    chk1("busy_o", 1'b1, busy_o);
    check("prog_state_o", {6'h00, PROG_RUN}, {6'h00, prog_state_o});
    rd8(CTL, 8'h02);
    rd8(8'h05, v);
    chk1("busy_o", 1'b0, busy_o);
    $display("done: single byte");
    wr8(CTL, 8'h05);
    for (int i = 0; i < 8; i++) begin
      row[i] = 8'($random(seed));
      wr8(8'(24 + i), row[i]);
    end
    wr8(CTL, 8'h0d);
    for (int i = 0; i < 8; i++) rd8(8'(24 + i), row[i]);
    $display("done: full row");
    wr8(CTL, 8'h05);
    req(1'b0, 8'h18, 8'h00, 1'b1, 8'h00);
    req(1'b1, BNK, 8'(`NVM_BANK_EE1), 1'b1, 8'h00);
    for (int i = 0; i < 4; i++) begin
      if (i != 1) begin
        row[i] = ~row[i];
        wr8(8'(24 + i), row[i]);
      end
    end
    req(1'b1, 8'h20, 8'h00, 1'b1, 8'h00);
    wr8(CTL, 8'h0d);
    for (int i = 0; i < 8; i++) rd8(8'(24 + i), row[i]);
    wr8(CTL, 8'h09);
    chk1("busy_o", 1'b0, busy_o);
    wr8(CTL, 8'h04);
    wr8(CTL, 8'h0c);
    chk1("busy_o", 1'b0, busy_o);
    $display("done: partial row");
    wr8(CTL, 8'h05);
    wr8(8'h1c, ~row[4]);
    wr8(CTL, 8'h01);
    chk1("busy_o", 1'b0, busy_o);
    rd8(8'h1c, row[4]);
    $display("done: abandon");
    wr8(CTL, 8'h41);
    chk1("standby_o", 1'b1, standby_o);
    rd8(8'h18, 8'h00);
    wr8(CTL, 8'h01);
    rd8(8'h18, row[0]);
    @(posedge clock_i);
    stop_i <= 1'b1;
    rd8(8'h18, 8'h00);
    @(posedge clock_i);
    stop_i <= 1'b0;
    rd8(8'h18, row[0]);
    $display("done: standby and stop");
    u = ~v;
    wr8(BNK, 8'(`NVM_BANK_EE1));
    wr8(8'h05, u);
    rd8(8'h05, u);
    wr8(BNK, 8'(`NVM_BANK_EE0));
    rd8(8'h05, v);
    $display("done: second page");
    wrap_up();
  end
endmodule : eeprom_row_write_control_bench
